// ### rtl/acr_clk_div.sv
module acr_clk_div
    import acr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    acr_core_if.div cif
);

    logic [DIV_CNT_W-1:0] cnt_r;
    logic [DIV_CNT_W-1:0] cnt_nxt;
    wire logic [DIV_CNT_W-1:0] limit;

    // divide by two to the power of the field: terminal count 2^n - 1
    assign limit = DIV_CNT_W'((8'h1 << cif.div_sel) - 8'h1); // see [RULE_11]
    assign cif.tick = cif.conv_on && (cnt_r == limit);
    // counter parks at zero while off so the first tick is a full period
    assign cnt_nxt = (!cif.conv_on || cif.tick) ? '0 : cnt_r + 1'b1;

    // divider counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

endmodule : acr_clk_div

// ### rtl/acr_conv_seq.sv
module acr_conv_seq
    import acr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control side
    acr_core_if.seq cif,
    // analog core
    output logic core_start,
    input wire logic core_done,
    input wire logic [RES_W-1:0] core_data
);

    acr_seq_t state_r;
    acr_seq_t state_nxt;
    logic [RES_W-1:0] result_r;
    logic [RES_W-1:0] result_nxt;
    logic start_r;
    wire logic launch;
    wire logic finish;

    // a start while off or busy is dropped; the top flags it
    assign launch = (state_r == SEQ_IDLE) && cif.start_trig && cif.conv_on; // see [RULE_16]
    assign finish = (state_r == SEQ_RUN) && cif.conv_on && core_done;

    // next state: switching off aborts a running conversion
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            SEQ_IDLE: if (launch) state_nxt = SEQ_RUN; // see [RULE_01]
            SEQ_RUN: if (finish || !cif.conv_on) state_nxt = SEQ_IDLE; // see [RULE_03]
        endcase
    end

    // result is held at zero while the converter is off
    assign result_nxt = !cif.conv_on ? RES_RST : (finish ? core_data : result_r); // see [RULE_05]

    // sequencer flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= SEQ_IDLE;
            result_r <= RES_RST;
            start_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            result_r <= result_nxt;
            start_r <= launch;
        end
    end

    // busy only follows the sequencer, never a bus write
    assign cif.busy = (state_r == SEQ_RUN); // see [RULE_02] see [RULE_04]
    assign cif.done_evt = finish;
    assign cif.result = result_r;
    assign core_start = start_r;

endmodule : acr_conv_seq

// ### rtl/acr_top.sv
// Notes on behaviour
// [RULE_01] writing start high then low launches a conversion; nothing else does
// [RULE_02] a launched conversion sets the busy flag
// [RULE_03] busy clears once the conversion finishes
// [RULE_04] busy is read-only; bus writes never change it
// [RULE_05] enable bit turns converter on; while off both result bytes read zero
// [RULE_06] justify bit picks left (11:4 / 3:0) or right (11:8 / 7:0) layout
// [RULE_07] main bits 3:2 and source-clock bits 4:3 read as zero
// [RULE_08] two-bit channel field picks external pin 0 to 3
// [RULE_09] source field: external, supply, supply/2, /4, amp, amp/2, amp/4
// [RULE_10] internal source disconnects the named external channel
// [RULE_11] conversion clock is system clock divided by two to the field
// [RULE_12] amplifier output is reference pin times 1-4 or bandgap times 2-4
// [RULE_13] left justified low byte keeps its lower nibble zero; unused bits zero
// [RULE_14] external and internal chosen together routes only the internal one
// [RULE_15] software waits for busy low and keeps converter on meanwhile
// [RULE_16] start while disabled sets no busy; everything resets to zero
//
// Register access over AXI4-Lite and the register addresses were decided locally.
module acr_top
    import acr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // analog core
    output logic core_start,
    output logic core_clk_tick,
    input wire logic core_done,
    input wire logic [RES_W-1:0] core_data,
    // analog input routing
    output logic [CHAN_W-1:0] ext_channel_sel,
    output logic ext_channel_connect,
    output logic [1:0] input_kind,
    output logic [1:0] input_scale,
    // interrupt
    output logic irq
);

    acr_core_if cif ();

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic start_r;
    logic on_r;
    logic justify_r;
    logic [CHAN_W-1:0] chan_r;
    logic [SRC_W-1:0] src_r;
    logic [DIV_W-1:0] div_r;
    logic [EVT_W-1:0] irq_st_r;
    logic [EVT_W-1:0] irq_st_nxt;
    logic [EVT_W-1:0] irq_msk_r;

    // bus state
    logic aw_got_r;
    logic w_got_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_byte_r;
    logic w_lane_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    wire logic aw_take;
    wire logic w_take;
    wire logic commit;
    wire logic wr_lane;
    wire logic wr_main;
    wire logic wr_src_clk;
    wire logic wr_irq_st;
    wire logic wr_irq_msk;
    wire logic wr_hit;
    wire logic start_trig;
    wire logic refused;

    // address and data are caught separately, in either order
    assign awready = !aw_got_r && !bvalid_r;
    assign wready = !w_got_r && !bvalid_r;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign commit = aw_got_r && w_got_r && !bvalid_r;

    // decode of the committed write; only byte lane 0 carries data
    assign wr_lane = commit && w_lane_r;
    assign wr_main = wr_lane && (aw_addr_r == OFF_MAIN);
    assign wr_src_clk = wr_lane && (aw_addr_r == OFF_SRC_CLK);
    assign wr_irq_st = wr_lane && (aw_addr_r == OFF_IRQ_ST);
    assign wr_irq_msk = wr_lane && (aw_addr_r == OFF_IRQ_MSK);
    assign wr_hit = (aw_addr_r == OFF_MAIN) || (aw_addr_r == OFF_SRC_CLK)
        || (aw_addr_r == OFF_RES_HI) || (aw_addr_r == OFF_RES_LO)
        || (aw_addr_r == OFF_IRQ_ST) || (aw_addr_r == OFF_IRQ_MSK);

    // the falling write of start after a rising one is the only trigger
    assign start_trig = wr_main && start_r && !w_byte_r[START_BIT]; // see [RULE_01]
    // a trigger that cannot launch is reported, not queued
    assign refused = start_trig && (!on_r || cif.busy); // see [RULE_16]

    // bus flops for the write path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_addr_r <= {awaddr[ADDR_W-1:2], 2'h0};
            if (w_take)
            begin
                w_byte_r <= wdata[7:0];
                w_lane_r <= wstrb[0];
            end
            aw_got_r <= commit ? 1'b0 : (aw_got_r || aw_take);
            w_got_r <= commit ? 1'b0 : (w_got_r || w_take);
            if (commit)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // the busy bit of a write is dropped, so software cannot fake it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_r <= MAIN_RST[START_BIT]; // see [RULE_16]
            on_r <= MAIN_RST[ON_BIT];
            justify_r <= MAIN_RST[JUSTIFY_BIT];
            chan_r <= MAIN_RST[CHAN_LSB +: CHAN_W];
            src_r <= SRC_CLK_RST[SRC_LSB +: SRC_W];
            div_r <= SRC_CLK_RST[DIV_LSB +: DIV_W];
            irq_msk_r <= EVT_RST;
        end
        else
        begin
            if (wr_main)
            begin
                start_r <= w_byte_r[START_BIT];
                on_r <= w_byte_r[ON_BIT]; // see [RULE_05]
                justify_r <= w_byte_r[JUSTIFY_BIT]; // see [RULE_06]
                chan_r <= w_byte_r[CHAN_LSB +: CHAN_W]; // see [RULE_08]
            end
            if (wr_src_clk)
            begin
                src_r <= w_byte_r[SRC_LSB +: SRC_W]; // see [RULE_09]
                div_r <= w_byte_r[DIV_LSB +: DIV_W]; // see [RULE_11]
            end
            if (wr_irq_msk)
                irq_msk_r <= w_byte_r[EVT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    // write one to clear; an event in the same cycle wins over the clear
    assign irq_st_nxt = (irq_st_r & ~(wr_irq_st ? w_byte_r[EVT_W-1:0] : EVT_RST))
        | {refused, cif.done_evt};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_st_r <= EVT_RST;
        else
            irq_st_r <= irq_st_nxt;
    end

    assign irq = |(irq_st_r & irq_msk_r);

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    wire logic ar_take;
    wire logic [ADDR_W-1:0] rd_addr;
    wire logic [7:0] main_rd;
    wire logic [7:0] src_clk_rd;
    wire logic [7:0] rd_byte;
    wire logic rd_hit;

    assign arready = !rvalid_r;
    assign ar_take = arvalid && arready;
    assign rd_addr = {araddr[ADDR_W-1:2], 2'h0};

    // unimplemented bit positions are packed as zero
    assign main_rd = {start_r, cif.busy, on_r, justify_r, 2'h0, chan_r}; // see [RULE_07]
    assign src_clk_rd = {src_r, 2'h0, div_r}; // see [RULE_07]

    // result bytes are formatted on read; the sequencer holds zero while off
    assign rd_byte = (rd_addr == OFF_MAIN) ? main_rd
        : (rd_addr == OFF_SRC_CLK) ? src_clk_rd
        : (rd_addr == OFF_RES_HI) ? acr_fmt_hi(justify_r, cif.result) // see [RULE_06]
        : (rd_addr == OFF_RES_LO) ? acr_fmt_lo(justify_r, cif.result) // see [RULE_13]
        : (rd_addr == OFF_IRQ_ST) ? {6'h00, irq_st_r}
        : (rd_addr == OFF_IRQ_MSK) ? {6'h00, irq_msk_r}
        : 8'h00;
    assign rd_hit = (rd_addr == OFF_MAIN) || (rd_addr == OFF_SRC_CLK)
        || (rd_addr == OFF_RES_HI) || (rd_addr == OFF_RES_LO)
        || (rd_addr == OFF_IRQ_ST) || (rd_addr == OFF_IRQ_MSK);

    // read data is captured so it stands while the master stalls
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rready)
            rvalid_r <= 1'b0;
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // ------------------------------------------------------------
    // input routing
    // ------------------------------------------------------------
    wire logic src_internal;

    // codes with nonzero low bits are internal; they override the pin choice
    assign src_internal = |src_r[1:0]; // see [RULE_14]
    assign ext_channel_sel = chan_r; // see [RULE_08]
    assign ext_channel_connect = !src_internal; // see [RULE_10]
    // amplifier gain and reference live in the analog block, we only route it
    assign input_kind = !src_internal ? KIND_EXT
        : (src_r[2] ? KIND_AMP : KIND_SUPPLY); // see [RULE_09] see [RULE_12]
    assign input_scale = src_internal ? (src_r[1:0] - 2'h1) : 2'h0;

    // ------------------------------------------------------------
    // converter core control
    // ------------------------------------------------------------
    assign cif.conv_on = on_r;
    assign cif.start_trig = start_trig;
    assign cif.div_sel = div_r;
    assign core_clk_tick = cif.tick;

    acr_clk_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif)
    );

    acr_conv_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif),
        .core_start(core_start),
        .core_done(core_done),
        .core_data(core_data)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // cycles since the last conversion clock tick, restarted like the divider
    logic [DIV_CNT_W:0] gap_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !on_r || cif.tick)
            gap_r <= '0;
        else
            gap_r <= gap_r + 1'b1;
    end
    a_start_sets_busy: assert property (start_trig && on_r && !cif.busy // see [RULE_02]
        |=> cif.busy && core_start) else $error("start sequence did not raise busy");
    a_done_clears_busy: assert property (cif.busy && on_r && core_done // see [RULE_03]
        |=> !cif.busy ##0 irq_st_r[EVT_DONE]) else $error("busy not cleared at conversion end");
    a_busy_read_only: assert property (!start_trig && !core_done && on_r // see [RULE_04]
        |=> $stable(cif.busy)) else $error("busy changed without converter cause");
    a_off_result_zero: assert property (!on_r // see [RULE_05]
        |=> cif.result == RES_RST ##1 !cif.busy) else $error("result not cleared while off");
    a_read_result_fmt: assert property (ar_take && rd_addr == OFF_RES_LO // see [RULE_13]
        |=> rdata[31:8] == 24'h00_0000 && (!$past(justify_r) -> rdata[3:0] == 4'h0))
        else $error("result low byte layout wrong");
    a_unimpl_zero: assert property (ar_take && rd_addr == OFF_MAIN // see [RULE_07]
        |=> rdata[3:2] == 2'h0 && rdata[6] == $past(cif.busy))
        else $error("main register unimplemented bits not zero");
    a_internal_isolates: assert property (wr_src_clk && |w_byte_r[SRC_LSB +: 2] // see [RULE_10]
        |=> !ext_channel_connect && input_kind != KIND_EXT)
        else $error("external channel left connected");
    a_div_period: assert property (gap_r < (8'h1 << div_r)) // see [RULE_11]
        else $error("conversion clock tick period too long");
    a_off_no_busy: assert property (start_trig && !on_r && !cif.busy // see [RULE_16]
        |=> !cif.busy && irq_st_r[EVT_REFUSED]) else $error("start while off raised busy");

endmodule : acr_top

// ### shared/acr_core_if.sv
interface acr_core_if;
    import acr_pkg::*;
    logic conv_on;
    logic start_trig;
    logic [DIV_W-1:0] div_sel;
    logic tick;
    logic busy;
    logic done_evt;
    logic [RES_W-1:0] result;

    modport ctl (output conv_on, output start_trig, output div_sel,
                 input tick, input busy, input done_evt, input result);
    modport div (input conv_on, input div_sel, output tick);
    modport seq (input conv_on, input start_trig, input tick,
                 output busy, output done_evt, output result);
endinterface : acr_core_if

// ### shared/acr_pkg.sv
package acr_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_MAIN = 8'h00;
    localparam logic [7:0] OFF_SRC_CLK = 8'h04;
    localparam logic [7:0] OFF_RES_HI = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0c;
    localparam logic [7:0] OFF_IRQ_ST = 8'h10;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h14;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned START_BIT = 7;
    localparam int unsigned BUSY_BIT = 6;
    localparam int unsigned ON_BIT = 5;
    localparam int unsigned JUSTIFY_BIT = 4;
    localparam int unsigned CHAN_LSB = 0;
    localparam int unsigned CHAN_W = 2;
    localparam int unsigned SRC_LSB = 5;
    localparam int unsigned SRC_W = 3;
    localparam int unsigned DIV_LSB = 0;
    localparam int unsigned DIV_W = 3;
    localparam int unsigned DIV_CNT_W = 7;
    localparam int unsigned RES_W = 12;
    localparam logic [7:0] MAIN_RST = 8'h00;
    localparam logic [7:0] SRC_CLK_RST = 8'h00;
    localparam logic [11:0] RES_RST = 12'h000;

    // interrupt events
    localparam int unsigned EVT_W = 2;
    localparam int unsigned EVT_DONE = 0;
    localparam int unsigned EVT_REFUSED = 1;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

    // source kinds seen by the analog mux
    localparam logic [1:0] KIND_EXT = 2'h0;
    localparam logic [1:0] KIND_SUPPLY = 2'h1;
    localparam logic [1:0] KIND_AMP = 2'h2;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {SEQ_IDLE, SEQ_RUN} acr_seq_t;

    // high result byte for the chosen justification
    function automatic logic [7:0] acr_fmt_hi(input logic just, input logic [11:0] d);
        acr_fmt_hi = just ? {4'h0, d[11:8]} : d[11:4];
    endfunction : acr_fmt_hi

    // low result byte; left justified keeps the low nibble zero
    function automatic logic [7:0] acr_fmt_lo(input logic just, input logic [11:0] d);
        acr_fmt_lo = just ? d[7:0] : {d[3:0], 4'h0};
    endfunction : acr_fmt_lo

endpackage : acr_pkg

// ### verification/adc_control_registers_test.sv
module adc_control_registers_test
    import acr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, core_start, core_clk_tick, core_done;
    logic ext_channel_connect, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, ext_channel_sel, input_kind, input_scale;
    logic [11:0] core_data;
    int miscompares, checked, starts;

    acr_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .core_start(core_start), .core_clk_tick(core_clk_tick),
        .core_done(core_done), .core_data(core_data),
        .ext_channel_sel(ext_channel_sel), .ext_channel_connect(ext_channel_connect),
        .input_kind(input_kind), .input_scale(input_scale), .irq(irq)
    );

    // 40 MHz system clock
    always #12.5 aclk = ~aclk;

    // count launches at mid-cycle so the registered pulse is settled
    always @(negedge aclk)
        if (core_start === 1'b1) starts++;

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s response expected %h seen %h", what, exp, got);
        end
    endtask : chk_resp

    // handshakes are judged at the falling edge, i.e. what the next rising edge will see
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic pa, pw, got;
        logic [1:0] r;
        pa = 1'b1;
        pw = 1'b1;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        while (pa || pw)
        begin
            @(negedge aclk);
            if (awready === 1'b1) pa = 1'b0;
            if (wready === 1'b1) pw = 1'b0;
            @(posedge aclk);
            if (!pa) awvalid <= 1'b0;
            if (!pw) wvalid <= 1'b0;
        end
        do
        begin
            @(negedge aclk);
            got = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (got !== 1'b1);
        chk_resp("write", er, r);
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp,
                      input logic [1:0] er);
        logic got;
        logic [31:0] d;
        logic [1:0] r;
        arvalid <= 1'b1;
        araddr <= a;
        do
        begin
            @(negedge aclk);
            got = arready;
            @(posedge aclk);
        end while (got !== 1'b1);
        arvalid <= 1'b0;
        do
        begin
            @(negedge aclk);
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end while (got !== 1'b1);
        chk(what, {24'h0, exp}, d);
        chk_resp(what, er, r);
    endtask : rd

    // spacing between two consecutive conversion clock ticks
    task automatic tick_gap(input int n);
        int gap;
        do @(negedge aclk); while (core_clk_tick !== 1'b1);
        gap = 0;
        do
        begin
            @(negedge aclk);
            gap++;
        end while (core_clk_tick !== 1'b1);
        chk("tick gap", 32'(1 << n), 32'(gap));
        @(posedge aclk);
    endtask : tick_gap

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // generous bound: the whole sequence needs well under 4000 cycles
    initial
    begin
        #200000;
        miscompares++;
        results();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] offs [6];
        logic [2:0] sv;
        logic [1:0] c, k, sc;
        offs = '{OFF_MAIN, OFF_SRC_CLK, OFF_RES_HI, OFF_RES_LO, OFF_IRQ_ST, OFF_IRQ_MSK};
        {aclk, aresetn, awvalid, wvalid, arvalid, core_done} = '0;
        {awaddr, araddr, wdata, wstrb, core_data} = '0;
        bready = 1'b1;
        rready = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (offs[i]) rd("reset value", offs[i], 8'h00, RESP_OKAY);
        // busy and unused bits ignore writes; start falling while off is refused
        wr(OFF_MAIN, 8'hdf, RESP_OKAY);
        rd("main readback", OFF_MAIN, 8'h93, RESP_OKAY);
        wr(OFF_SRC_CLK, 8'hff, RESP_OKAY);
        rd("source clock readback", OFF_SRC_CLK, 8'he7, RESP_OKAY);
        wr(OFF_MAIN, 8'h13, RESP_OKAY);
        rd("busy while off", OFF_MAIN, 8'h13, RESP_OKAY);
        rd("refused event", OFF_IRQ_ST, 8'h02, RESP_OKAY);
        wr(OFF_IRQ_ST, 8'h02, RESP_OKAY);
        rd("status cleared", OFF_IRQ_ST, 8'h00, RESP_OKAY);
        // one real conversion, with a second start refused meanwhile
        wr(OFF_IRQ_MSK, 8'h01, RESP_OKAY);
        wr(OFF_MAIN, 8'ha0, RESP_OKAY);
        wr(OFF_MAIN, 8'h20, RESP_OKAY);
        rd("busy set", OFF_MAIN, 8'h60, RESP_OKAY);
        wr(OFF_MAIN, 8'ha0, RESP_OKAY);
        wr(OFF_MAIN, 8'h20, RESP_OKAY);
        rd("busy kept", OFF_MAIN, 8'h60, RESP_OKAY);
        rd("refused while busy", OFF_IRQ_ST, 8'h02, RESP_OKAY);
        chk("launch count", 32'h1, 32'(starts));
        @(negedge aclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        @(posedge aclk);
        core_data <= 12'habc;
        core_done <= 1'b1;
        @(posedge aclk);
        core_done <= 1'b0;
        core_data <= 12'h543;
        rd("busy cleared", OFF_MAIN, 8'h20, RESP_OKAY);
        @(negedge aclk);
        chk("irq on done", 32'h1, {31'h0, irq});
        @(posedge aclk);
        rd("both events", OFF_IRQ_ST, 8'h03, RESP_OKAY);
        wr(OFF_IRQ_ST, 8'h03, RESP_OKAY);
        @(negedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        @(posedge aclk);
        // justification, read only once busy is low, then switching off clears the result
        rd("left high", OFF_RES_HI, 8'hab, RESP_OKAY);
        rd("left low", OFF_RES_LO, 8'hc0, RESP_OKAY);
        wr(OFF_MAIN, 8'h30, RESP_OKAY);
        rd("right high", OFF_RES_HI, 8'h0a, RESP_OKAY);
        rd("right low", OFF_RES_LO, 8'hbc, RESP_OKAY);
        wr(OFF_MAIN, 8'h10, RESP_OKAY);
        rd("off high", OFF_RES_HI, 8'h00, RESP_OKAY);
        rd("off low", OFF_RES_LO, 8'h00, RESP_OKAY);
        // every source code, each with a channel code that differs from it
        for (int s = 0; s < 8; s++)
        begin
            sv = 3'(s);
            c = ~sv[1:0];
            k = (sv[1:0] == 2'h0) ? KIND_EXT : (sv[2] ? KIND_AMP : KIND_SUPPLY);
            sc = (sv[1:0] == 2'h0) ? 2'h0 : sv[1:0] - 2'h1;
            wr(OFF_SRC_CLK, {sv, 5'h00}, RESP_OKAY);
            wr(OFF_MAIN, {6'h08, c}, RESP_OKAY);
            @(negedge aclk);
            chk("channel", 32'(c), 32'(ext_channel_sel));
            chk("connect", 32'(sv[1:0] == 2'h0), 32'(ext_channel_connect));
            chk("kind", 32'(k), 32'(input_kind));
            chk("scale", 32'(sc), 32'(input_scale));
            @(posedge aclk);
        end
        // every divider code
        wr(OFF_MAIN, 8'h20, RESP_OKAY);
        for (int n = 0; n < 8; n++)
        begin
            wr(OFF_SRC_CLK, 8'(n), RESP_OKAY);
            tick_gap(n);
        end
        wr(8'h40, 8'h5a, RESP_SLVERR);
        rd("unmapped", 8'h40, 8'h00, RESP_SLVERR);
        results();
    end

endmodule : adc_control_registers_test
